// >>> design/exec_pkg.sv
// Constants for the instruction execute block: opcodes, software map,
// flag positions and reset values. Shared by design and bench.
package exec_pkg;
	// Instruction word and operand widths
	localparam int INSTR_W = 16;
	localparam int PC_W = 11;
	localparam int FILE_WORDS = 192;
	localparam int STACK_DEPTH = 8;
	localparam logic [7:0] FILE_LAST = 8'hbf;
	localparam logic [10:0] PC_RESET = 11'h000;
	// Field [15:11]: bit operations, branches, immediate ops
	localparam logic [4:0] OP_BIT_CLR = 5'h0c;
	localparam logic [4:0] OP_BIT_SET = 5'h0d;
	localparam logic [4:0] OP_BIT_TZ = 5'h0e;
	localparam logic [4:0] OP_BIT_TO = 5'h0f;
	localparam logic [4:0] OP_CALL = 5'h14;
	localparam logic [4:0] OP_GOTO = 5'h15;
	localparam logic [4:0] OP_LOAD_IMM = 5'h16;
	localparam logic [4:0] OP_OR_IMM = 5'h17;
	// Field [15:9]: file operations, bit 8 is destination select except for acc-to-file, which always writes the file
	localparam logic [6:0] OP_DAS = 7'h02;
	localparam logic [6:0] OP_DEC = 7'h04;
	localparam logic [6:0] OP_DEC_SZ = 7'h06;
	localparam logic [6:0] OP_INC = 7'h08;
	localparam logic [6:0] OP_INC_SZ = 7'h0a;
	localparam logic [6:0] OP_OR_FILE = 7'h0c;
	localparam logic [6:0] OP_COPY_FL = 7'h0e;
	localparam logic [6:0] OP_COPY_UNFL = 7'h10;
	localparam logic [6:0] OP_ACC_TO_FILE = 7'h12;
	// Whole-word instructions
	localparam logic [15:0] INSTR_NOP = 16'h0000;
	localparam logic [15:0] INSTR_RET_PLAIN = 16'h0004;
	localparam logic [15:0] INSTR_RET_EN = 16'h0005;
	// Software map above the file registers
	localparam logic [7:0] ADDR_ACCUM = 8'hc0;
	localparam logic [7:0] ADDR_FLAGS = 8'hc1;
	localparam logic [7:0] ADDR_PC_LO = 8'hc2;
	localparam logic [7:0] ADDR_PC_HI = 8'hc3;
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_GIE = 2;
	// Decimal adjust thresholds
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [7:0] ADJ_LO = 8'h06;
	localparam logic [7:0] ADJ_HI = 8'h60;
	// Execute phase
	typedef enum logic [1:0] {ST_EXEC = 2'b00, ST_FLUSH = 2'b01} phase_type;
endpackage

// >>> design/mcu_instruction_execute.sv
// Execute stage of a small 8-bit core: file registers, accumulator,
// flags, program counter, return stack and a software access port.
// Assumes fetch logic on the same clock presents the word at pc_out.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module mcu_instruction_execute #(
	parameter int STACK_DEPTH = exec_pkg::STACK_DEPTH
)(
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [exec_pkg::INSTR_W-1:0] instr_in,
	input wire logic instr_valid_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	output logic [7:0] rd_data_out,
	output logic [exec_pkg::PC_W-1:0] pc_out,
	output logic [2:0] upper_pc_latch_out,
	output logic [7:0] accum_out,
	output logic zero_out,
	output logic carry_out,
	output logic master_irq_enable_out,
	output logic nop_slot_out
);
	import exec_pkg::*;

	localparam int SP_W = $clog2(STACK_DEPTH);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		phase_type phase;
		logic hold;
		logic [PC_W-1:0] pc;
		logic [2:0] upc;
		logic [7:0] acc;
		logic z;
		logic c;
		logic master_irq_enable;
		logic [SP_W-1:0] sp;
		logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
		logic [FILE_WORDS-1:0][7:0] regs;
		logic [7:0] rd_data;
	} core_state_type;

	core_state_type cur_ff;
	core_state_type nxt_state;
	logic exec_go;
	logic [7:0] opnd;
	logic [PC_W-1:0] stack_top;

	// Operand fetch and stack top
	assign exec_go = instr_valid_in && (cur_ff.phase == ST_EXEC) && !wr_en_in;
	assign opnd = (instr_in[7:0] <= FILE_LAST) ? cur_ff.regs[instr_in[7:0]] : 8'h00;
	assign stack_top = cur_ff.stack[cur_ff.sp - SP_W'(1)];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [7:0] res;
		logic [7:0] bit_mask;
		logic [7:0] das_val;
		logic store;
		logic to_file;
		logic upd_z;
		logic skip;
		nxt_state = cur_ff;
		res = 8'h00;
		bit_mask = 8'h01 << instr_in[10:8];
		das_val = opnd;
		store = 1'b0;
		to_file = instr_in[8];
		upd_z = 1'b0;
		skip = 1'b0;
		nxt_state.rd_data = 8'h00;
		if (instr_valid_in)
		begin
			case (cur_ff.phase)
				ST_FLUSH:
				begin
					// Substituted nop; branches keep the target address
					nxt_state.phase = ST_EXEC;
					if (!cur_ff.hold)
						nxt_state.pc = cur_ff.pc + 11'h001;
				end
				default:
				begin
					nxt_state.pc = cur_ff.pc + 11'h001;
					if ((instr_in[15:11] == OP_BIT_CLR) || (instr_in[15:11] == OP_BIT_SET))
					begin
						res = (instr_in[15:11] == OP_BIT_SET) ? (opnd | bit_mask) : (opnd & ~bit_mask);
						store = 1'b1;
						to_file = 1'b1;
					end
					else if (instr_in[15:11] == OP_BIT_TZ)
						skip = ((opnd & bit_mask) == 8'h00);
					else if (instr_in[15:11] == OP_BIT_TO)
						skip = ((opnd & bit_mask) != 8'h00);
					else if ((instr_in[15:11] == OP_CALL) || (instr_in[15:11] == OP_GOTO))
					begin
						// Call pushes the return address, both then jump
						if (instr_in[15:11] == OP_CALL)
						begin
							nxt_state.stack[cur_ff.sp] = cur_ff.pc + 11'h001;
							nxt_state.sp = cur_ff.sp + SP_W'(1);
						end
						nxt_state.pc = instr_in[10:0];
						nxt_state.upc = instr_in[10:8];
						nxt_state.phase = ST_FLUSH;
						nxt_state.hold = 1'b1;
					end
					else if (instr_in[15:11] == OP_LOAD_IMM)
					begin
						res = instr_in[7:0];
						store = 1'b1;
						to_file = 1'b0;
					end
					else if (instr_in[15:11] == OP_OR_IMM)
					begin
						res = cur_ff.acc | instr_in[7:0];
						store = 1'b1;
						to_file = 1'b0;
						upd_z = 1'b1;
					end
					else if (instr_in[15:9] == OP_DAS)
					begin
						// Undo borrow per nibble, carry reports no high borrow
						if (opnd[3:0] > BCD_MAX)
							das_val = das_val - ADJ_LO;
						nxt_state.c = (opnd[7:4] <= BCD_MAX) && cur_ff.c;
						if (!nxt_state.c)
							das_val = das_val - ADJ_HI;
						res = das_val;
						store = 1'b1;
					end
					else if ((instr_in[15:9] == OP_DEC) || (instr_in[15:9] == OP_DEC_SZ))
					begin
						// Plain form updates zero, skip form skips on zero
						res = opnd - 8'h01;
						store = 1'b1;
						upd_z = (instr_in[15:9] == OP_DEC);
						skip = (instr_in[15:9] == OP_DEC_SZ) && (res == 8'h00);
					end
					else if ((instr_in[15:9] == OP_INC) || (instr_in[15:9] == OP_INC_SZ))
					begin
						res = opnd + 8'h01;
						store = 1'b1;
						upd_z = (instr_in[15:9] == OP_INC);
						skip = (instr_in[15:9] == OP_INC_SZ) && (res == 8'h00);
					end
					else if (instr_in[15:9] == OP_OR_FILE)
					begin
						res = cur_ff.acc | opnd;
						store = 1'b1;
						upd_z = 1'b1;
					end
					else if (instr_in[15:9] == OP_COPY_FL)
					begin
						res = opnd;
						store = 1'b1;
						upd_z = 1'b1;
					end
					else if (instr_in[15:9] == OP_COPY_UNFL)
					begin
						res = opnd;
						store = 1'b1;
					end
					else if (instr_in[15:9] == OP_ACC_TO_FILE)
					begin
						res = cur_ff.acc;
						store = 1'b1;
						to_file = 1'b1;
					end
					else if ((instr_in == INSTR_RET_PLAIN) || (instr_in == INSTR_RET_EN))
					begin
						// Pop return address; only the enabling form sets enable
						nxt_state.sp = cur_ff.sp - SP_W'(1);
						nxt_state.pc = stack_top;
						nxt_state.phase = ST_FLUSH;
						nxt_state.hold = 1'b1;
						if (instr_in == INSTR_RET_EN)
							nxt_state.master_irq_enable = 1'b1;
					end
					// Anything else, including the nop word, changes nothing but the program counter
				end
			endcase
		end
		// Result to destination
		if (store && !to_file)
			nxt_state.acc = res;
		if (store && to_file && (instr_in[7:0] <= FILE_LAST))
			nxt_state.regs[instr_in[7:0]] = res;
		if (upd_z)
			nxt_state.z = (res == 8'h00);
		if (skip)
		begin
			nxt_state.phase = ST_FLUSH;
			nxt_state.hold = 1'b0;
		end
		// Software writes land after execution and win
		if (wr_en_in)
		begin
			if (addr_in <= FILE_LAST)
				nxt_state.regs[addr_in] = wr_data_in;
			else if (addr_in == ADDR_ACCUM)
				nxt_state.acc = wr_data_in;
			else if (addr_in == ADDR_FLAGS)
				{nxt_state.master_irq_enable, nxt_state.z, nxt_state.c} = wr_data_in[FLAG_GIE:FLAG_C];
			else if (addr_in == ADDR_PC_HI)
				nxt_state.upc = wr_data_in[2:0];
		end
		// Software reads, unmapped give zero
		if (rd_en_in)
		begin
			if (addr_in <= FILE_LAST)
				nxt_state.rd_data = cur_ff.regs[addr_in];
			else if (addr_in == ADDR_ACCUM)
				nxt_state.rd_data = cur_ff.acc;
			else if (addr_in == ADDR_FLAGS)
				nxt_state.rd_data = {5'h00, cur_ff.master_irq_enable, cur_ff.z, cur_ff.c};
			else if (addr_in == ADDR_PC_LO)
				nxt_state.rd_data = cur_ff.pc[7:0];
			else if (addr_in == ADDR_PC_HI)
				nxt_state.rd_data = {cur_ff.upc, 2'h0, cur_ff.pc[10:8]};
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cur_ff <= '0;
		end
		else
		begin
			cur_ff <= nxt_state;
		end
	end

	// Outputs straight from state
	assign rd_data_out = cur_ff.rd_data;
	assign pc_out = cur_ff.pc;
	assign upper_pc_latch_out = cur_ff.upc;
	assign accum_out = cur_ff.acc;
	assign zero_out = cur_ff.z;
	assign carry_out = cur_ff.c;
	assign master_irq_enable_out = cur_ff.master_irq_enable;
	assign nop_slot_out = cur_ff.phase[0]; // Only the slot phase has bit 0 set

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_bit_clear;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		exec_go && instr_in[15:11] == OP_BIT_CLR && instr_in[7:0] <= FILE_LAST |=>
		cur_ff.regs[$past(instr_in[7:0])][$past(instr_in[10:8])] == 1'b0
		&& $stable(zero_out) && $stable(carry_out) && !nop_slot_out;
	endproperty
	a_bit_clear: assert property (p_bit_clear)
		else $error("bit clear failed");

	property p_test_zero;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		exec_go && instr_in[15:11] == OP_BIT_TZ |=>
		nop_slot_out == ($past(opnd & (8'h01 << instr_in[10:8])) == 8'h00);
	endproperty
	a_test_zero: assert property (p_test_zero)
		else $error("test skip zero slot wrong");

	property p_call;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		exec_go && instr_in[15:11] == OP_CALL |=>
		pc_out == $past(instr_in[10:0]) && upper_pc_latch_out == $past(instr_in[10:8])
		&& nop_slot_out && stack_top == $past(pc_out) + 11'h001
		##1 pc_out == $past(pc_out) && nop_slot_out != $past(instr_valid_in);
	endproperty
	a_call: assert property (p_call)
		else $error("call target or timing wrong");

	property p_dec_acc;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		exec_go && instr_in[15:9] == OP_DEC && !instr_in[8] |=>
		accum_out == $past(opnd) - 8'h01 && zero_out == (accum_out == 8'h00);
	endproperty
	a_dec_acc: assert property (p_dec_acc)
		else $error("decrement to accumulator wrong");

	property p_dec_skip;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		exec_go && instr_in[15:9] == OP_DEC_SZ && opnd == 8'h01 |=>
		nop_slot_out && $stable(zero_out) && $stable(carry_out);
	endproperty
	a_dec_skip: assert property (p_dec_skip)
		else $error("decrement skip missed");

	property p_or_imm;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		exec_go && instr_in[15:11] == OP_OR_IMM |=>
		accum_out == ($past(accum_out) | $past(instr_in[7:0]))
		&& zero_out == (accum_out == 8'h00);
	endproperty
	a_or_imm: assert property (p_or_imm)
		else $error("or immediate wrong");

	property p_load_imm;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		exec_go && instr_in[15:11] == OP_LOAD_IMM |=>
		accum_out == $past(instr_in[7:0]) && $stable(zero_out) && !nop_slot_out;
	endproperty
	a_load_imm: assert property (p_load_imm)
		else $error("load immediate wrong");

	property p_ret_plain;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		exec_go && instr_in == INSTR_RET_PLAIN |=>
		$stable(master_irq_enable_out) && pc_out == $past(stack_top) && nop_slot_out;
	endproperty
	a_ret_plain: assert property (p_ret_plain)
		else $error("plain return wrong");

	property p_ret_enable;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		exec_go && instr_in == INSTR_RET_EN |=>
		master_irq_enable_out && pc_out == $past(stack_top) && nop_slot_out;
	endproperty
	a_ret_enable: assert property (p_ret_enable)
		else $error("enabling return wrong");

	property p_nop_slot;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		nop_slot_out && instr_valid_in && !wr_en_in |=>
		$stable(accum_out) && $stable(zero_out) && $stable(carry_out) && !nop_slot_out;
	endproperty
	a_nop_slot: assert property (p_nop_slot)
		else $error("substituted nop changed state");
endmodule

// >>> tb/tb.sv
// Self-checking bench for the execute block: integer reference model,
// driven through the instruction port and the software register port.
// Assumes exec_pkg is compiled first and a single 40 MHz clock.
`timescale 1ns/1ps
module tb;
	import exec_pkg::*;
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [15:0] instr_in = 16'h0000;
	logic instr_valid_in = 1'b0;
	logic [7:0] addr_in = 8'h00;
	logic [7:0] wr_data_in = 8'h00;
	logic wr_en_in = 1'b0;
	logic rd_en_in = 1'b0;
	logic [7:0] rd_data_out;
	logic [10:0] pc_out;
	logic [2:0] upper_pc_latch_out;
	logic [7:0] accum_out;
	logic zero_out;
	logic carry_out;
	logic master_irq_enable_out;
	logic nop_slot_out;
	int fails = 0;
	int samples_checked = 0;
	int mf[FILE_WORDS];
	int m_stk[STACK_DEPTH];
	int m_acc, m_z, m_c, m_gie, m_pc, m_upc, m_slot, m_hold, m_sp;
	logic [4:0] o5[6] = '{OP_BIT_CLR, OP_BIT_SET, OP_BIT_TZ, OP_BIT_TO, OP_LOAD_IMM, OP_OR_IMM};
	logic [6:0] o7[9] = '{OP_DAS, OP_DEC, OP_DEC_SZ, OP_INC, OP_INC_SZ, OP_OR_FILE,
		OP_COPY_FL, OP_COPY_UNFL, OP_ACC_TO_FILE};

	mcu_instruction_execute #(.STACK_DEPTH(STACK_DEPTH)) DUT (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.instr_in(instr_in),
		.instr_valid_in(instr_valid_in),
		.addr_in(addr_in),
		.wr_data_in(wr_data_in),
		.wr_en_in(wr_en_in),
		.rd_en_in(rd_en_in),
		.rd_data_out(rd_data_out),
		.pc_out(pc_out),
		.upper_pc_latch_out(upper_pc_latch_out),
		.accum_out(accum_out),
		.zero_out(zero_out),
		.carry_out(carry_out),
		.master_irq_enable_out(master_irq_enable_out),
		.nop_slot_out(nop_slot_out)
	);

	// Clock, 25 ns period
	initial
	begin
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end

	// ----------------------------------------
	// Reference model and checks
	// ----------------------------------------
	task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic check_state();
		chk(pc_out, 11'(m_pc), "pc");
		chk(11'(upper_pc_latch_out), 11'(m_upc), "upper latch");
		chk(11'(accum_out), 11'(m_acc), "accum");
		chk(11'({master_irq_enable_out, zero_out, carry_out}),
			11'({m_gie[0], m_z[0], m_c[0]}), "flags");
		chk(11'(nop_slot_out), 11'(m_slot), "nop slot");
	endtask

	function automatic int rdf(input int r);
		return (r <= int'(FILE_LAST)) ? mf[r] : 0;
	endfunction

	function automatic void wrf(input int r, input int v);
		if (r <= int'(FILE_LAST))
			mf[r] = v & 'hff;
	endfunction

	function automatic int rd_exp(input logic [7:0] a);
		if (a <= FILE_LAST)
			return mf[a];
		if (a == ADDR_ACCUM)
			return m_acc;
		if (a == ADDR_FLAGS)
			return m_gie * 4 + m_z * 2 + m_c;
		if (a == ADDR_PC_LO)
			return m_pc & 'hff;
		if (a == ADDR_PC_HI)
			return m_upc * 32 + (m_pc >> 8);
		return 0;
	endfunction

	// One instruction step of the model
	task automatic model(input logic [15:0] w);
		int r, b, v, res, skip;
		logic [6:0] op;
		r = int'(w[7:0]);
		b = int'(w[10:8]);
		v = rdf(r);
		op = w[15:9];
		skip = 0;
		res = -1;
		if (m_slot)
		begin
			m_slot = 0;
			m_pc = m_hold ? m_pc : (m_pc + 1) & 'h7ff;
			return;
		end
		m_pc = (m_pc + 1) & 'h7ff;
		m_hold = 0;
		case (w[15:11])
			OP_BIT_CLR: wrf(r, v & ~(1 << b));
			OP_BIT_SET: wrf(r, v | (1 << b));
			OP_BIT_TZ: skip = ((v >> b) & 1) == 0;
			OP_BIT_TO: skip = (v >> b) & 1;
			OP_CALL, OP_GOTO:
			begin
				if (w[15:11] == OP_CALL)
				begin
					m_stk[m_sp] = m_pc;
					m_sp = (m_sp + 1) % STACK_DEPTH;
				end
				m_pc = int'(w[10:0]);
				m_upc = b;
				m_slot = 1;
				m_hold = 1;
			end
			OP_LOAD_IMM: m_acc = r;
			OP_OR_IMM:
			begin
				m_acc = m_acc | r;
				m_z = m_acc == 0;
			end
			default: ;
		endcase
		case (op)
			OP_DAS:
			begin
				res = (v % 16 > BCD_MAX) ? v - 6 : v;
				m_c = !(v / 16 > BCD_MAX || m_c == 0);
				res = (res - (m_c ? 0 : 'h60)) & 'hff;
			end
			OP_DEC, OP_DEC_SZ: res = (v + 255) & 'hff;
			OP_INC, OP_INC_SZ: res = (v + 1) & 'hff;
			OP_OR_FILE: res = m_acc | v;
			OP_COPY_FL, OP_COPY_UNFL: res = v;
			OP_ACC_TO_FILE: wrf(r, m_acc);
			default: ;
		endcase
		if (op == OP_DEC || op == OP_INC || op == OP_OR_FILE || op == OP_COPY_FL)
			m_z = res == 0;
		if ((op == OP_DEC_SZ || op == OP_INC_SZ) && res == 0)
			skip = 1;
		if (res >= 0 && w[8])
			wrf(r, res);
		else if (res >= 0)
			m_acc = res;
		if (w == INSTR_RET_PLAIN || w == INSTR_RET_EN)
		begin
			m_sp = (m_sp + STACK_DEPTH - 1) % STACK_DEPTH;
			m_pc = m_stk[m_sp];
			m_slot = 1;
			m_hold = 1;
			m_gie = (w == INSTR_RET_EN) ? 1 : m_gie;
		end
		if (skip)
			m_slot = 1;
	endtask

	// Drivers: each sets every strobe; exec checks after one edge, bus_wr only updates the model, bus_rd checks after each of two edges
	task automatic exec(input logic [15:0] w, input logic valid);
		instr_in <= w;
		instr_valid_in <= valid;
		wr_en_in <= 1'b0;
		rd_en_in <= 1'b0;
		@(posedge clk_sys_in);
		if (valid)
			model(w);
		#1;
		check_state();
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		addr_in <= a;
		wr_data_in <= d;
		wr_en_in <= 1'b1;
		rd_en_in <= 1'b0;
		instr_valid_in <= 1'b0;
		@(posedge clk_sys_in);
		if (a <= FILE_LAST)
			mf[a] = d;
		else if (a == ADDR_ACCUM)
			m_acc = d;
		else if (a == ADDR_FLAGS)
			{m_gie, m_z, m_c} = {32'(d[2]), 32'(d[1]), 32'(d[0])};
		else if (a == ADDR_PC_HI)
			m_upc = d[2:0];
		#1;
	endtask

	task automatic bus_rd(input logic [7:0] a);
		int e;
		e = rd_exp(a);
		addr_in <= a;
		rd_en_in <= 1'b1;
		wr_en_in <= 1'b0;
		instr_valid_in <= 1'b0;
		@(posedge clk_sys_in);
		#1;
		rd_en_in <= 1'b0;
		chk(11'(rd_data_out), 11'(e), "read data");
		@(posedge clk_sys_in);
		#1;
		chk(11'(rd_data_out), 11'h000, "read idle");
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		int n;
		logic [7:0] r;
		logic [15:0] w;
		void'($urandom(1993));
		repeat (16) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		@(posedge clk_sys_in);
		#1;
		check_state();
		bus_rd(ADDR_FLAGS);
		bus_wr(ADDR_PC_LO, 8'h55);
		bus_wr(8'hc7, 8'h3c);
		bus_rd(8'hc7);
		bus_rd(ADDR_PC_LO);
		bus_wr(ADDR_PC_HI, 8'ha5);
		bus_rd(ADDR_PC_HI);
		bus_wr(ADDR_FLAGS, 8'h03);
		for (int b = 0; b < 8; b++)
		begin
			exec({OP_BIT_SET, 3'(b), 8'h10}, 1'b1);
			exec({OP_BIT_TO, 3'(b), 8'h10}, 1'b1);
			exec({OP_LOAD_IMM, 11'h0ff}, 1'b1);
			exec({OP_BIT_TZ, 3'(b), 8'h10}, 1'b1);
			exec({OP_BIT_TZ, 3'(b), 8'h11}, 1'b1);
			exec({OP_LOAD_IMM, 11'h0ff}, 1'b1);
			exec({OP_BIT_CLR, 3'(b), 8'h10}, 1'b1);
			exec({OP_BIT_TO, 3'(b), 8'h10}, 1'b1);
		end
		bus_wr(8'h20, 8'h01);
		exec({OP_DEC_SZ, 1'b1, 8'h20}, 1'b1);
		exec({OP_OR_IMM, 11'h0ff}, 1'b1);
		exec({OP_COPY_FL, 1'b1, 8'h20}, 1'b1);
		bus_wr(8'h21, 8'hff);
		exec({OP_INC_SZ, 1'b0, 8'h21}, 1'b1);
		exec({OP_OR_IMM, 11'h0ff}, 1'b1);
		for (int k = 0; k < 2; k++)
		begin
			exec({OP_CALL, 11'h5a3}, 1'b1);
			exec({OP_LOAD_IMM, 11'h0aa}, 1'b1);
			exec({OP_GOTO, 11'h2c7}, 1'b1);
			exec({OP_LOAD_IMM, 11'h0bb}, 1'b1);
			exec(k ? INSTR_RET_EN : INSTR_RET_PLAIN, 1'b1);
			exec(INSTR_NOP, 1'b1);
		end
		// Random mix of instructions, stalls and register traffic
		repeat (600)
		begin
			n = $urandom_range(0, 21);
			r = 8'($urandom_range(0, 191));
			w = (n < 6) ? {o5[n], 3'($urandom), r} : {o7[(n + 3) % 9], 1'($urandom), r};
			case (n)
				15: w = {OP_CALL, 3'($urandom), r};
				16: w = {OP_GOTO, 3'($urandom), r};
				17: w = INSTR_RET_PLAIN;
				18: w = INSTR_RET_EN;
				19: w = INSTR_NOP;
				default: ;
			endcase
			if (n == 20)
				bus_wr(8'($urandom), 8'($urandom));
			else if (n == 21)
				bus_rd(8'($urandom));
			else
				exec(w, 1'($urandom_range(0, 7) != 0));
		end
		for (int a = 0; a < FILE_WORDS; a++)
			bus_rd(8'(a));
		summarize();
	end

	// Watchdog against a hung run
	initial
	begin
		#200000;
		fails++;
		$display("mismatch at %0t: watchdog expired", $time);
		summarize();
	end

	task automatic summarize();
		$display("checks %0d failures %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
endmodule
